// File: common/smtc_pkg.sv
package smtc_pkg;
  localparam int unsigned CW = 24;
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 32;
  // register byte offsets
  localparam logic [7:0] OFS_CTL1 = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_TMR  = 8'h08;
  localparam logic [7:0] OFS_CPR  = 8'h0c;
  localparam logic [7:0] OFS_CPW  = 8'h10;
  localparam logic [7:0] OFS_PRD  = 8'h14;
  localparam logic [7:0] OFS_ISTS = 8'h18;
  localparam logic [7:0] OFS_ICLR = 8'h1c;
  localparam logic [7:0] OFS_IEN  = 8'h20;
  // control one fields
  localparam int unsigned B_GO  = 7;
  localparam int unsigned B_REP = 6;
  localparam int unsigned MODE_HI = 3;
  // status fields
  localparam int unsigned B_PUPD = 7;
  localparam int unsigned B_WUPD = 6;
  localparam int unsigned B_MCLR = 5;
  localparam int unsigned B_RUN = 2;
  localparam int unsigned B_WIN = 1;
  localparam int unsigned B_ACQ = 0;
  // interrupt bits
  localparam int unsigned IRQ_N  = 3;
  localparam int unsigned I_WID  = 0;
  localparam int unsigned I_PER  = 1;
  localparam int unsigned I_MTCH = 2;
  localparam logic [CW-1:0] PRD_RST = 24'hffffff;
  typedef enum logic [3:0] {
    MD_WINCNT = 4'ha,
    MD_GATED  = 4'h9,
    MD_COUNT  = 4'h8,
    MD_CAPT   = 4'h7,
    MD_TOF    = 4'h6,
    MD_GWIN   = 4'h5,
    MD_WIN    = 4'h4,
    MD_HILO   = 4'h3
  } smtc_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM  = 2'b01,
    ST_ACQ  = 2'b11
  } smtc_state_t;
endpackage

// File: rtl/smtc_edge.sv
`timescale 1ns/100ps
`default_nettype none
module smtc_edge
  import smtc_pkg::*;
#(
  parameter int unsigned N = 2
)(
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] lvl,
  output logic      [N-1:0] rise,
  output logic      [N-1:0] fall
);
  logic [N-1:0] prev;
  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_bit
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          prev[i] <= 1'b0;
        else
          prev[i] <= lvl[i];
      end
      assign rise[i] = lvl[i] & ~prev[i];
      assign fall[i] = ~lvl[i] & prev[i];
    end
  endgenerate
endmodule
`default_nettype wire

// File: rtl/smtc_capt.sv
`timescale 1ns/100ps
`default_nettype none
module smtc_capt
  import smtc_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          load,
  input  wire logic [CW-1:0] d,
  output logic      [CW-1:0] q
);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else if (load)
      q <= d;
  end
endmodule
`default_nettype wire

// File: rtl/smtc_top.sv
// Functional notes
// - go bit enables counting and acquisition
// - repeat bit selects repeated acquisitions
// - mode 1001 gated, 1000 counter, 1111 reserved
// - mode 0111 capture, 0110 time of flight
// - modes 0101, 0100 windowed, 0011 high/low
// - buffer update requests self clear after copy
// - counter clear request self clears after reset
// - running flag shows counter incrementing
// - window flag shows window input level
// - acquisition flag shows acquisition in progress
// - windowed counter captures on window edges
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module smtc_top
(
  input  wire logic                   ref_clk,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [smtc_pkg::AW-1:0] paddr,
  input  wire logic [smtc_pkg::DW-1:0] pwdata,
  output logic      [smtc_pkg::DW-1:0] prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   window_input,
  input  wire logic                   measured_signal,
  output logic                        irq
);
  import smtc_pkg::*;

  //////////////////////////////////////////////////////////////////
  logic              acquisition_go;
  logic              rep;
  logic [MODE_HI:0]  mode;
  logic              period_buffer_update_req;
  logic              width_buffer_update_req;
  logic              counter_clear_req;
  logic [CW-1:0]     main_counter;
  logic [CW-1:0]     period_limit;
  logic [CW-1:0]     period_capture;
  logic [CW-1:0]     width_capture;
  logic [IRQ_N-1:0]  ists;
  logic [IRQ_N-1:0]  ien;
  smtc_state_t       st;
  smtc_state_t       next_st;
  logic [CW-1:0]     next_count;
  logic              next_go;
  logic              mode_ok;
  logic              need_edge;
  logic              inc;
  logic              restart;
  logic              ld_per;
  logic              ld_wid;
  logic [DW-1:0]     rd_mux;
  logic              win_rise;
  logic              win_fall;
  logic              sig_rise;
  logic              sig_fall;
  //////////////////////////////////////////////////////////////////
  // apb decode; zero wait states
  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire setup   = psel & ~penable;
  wire hit_ctl = paddr == OFS_CTL1;
  wire hit_sts = paddr == OFS_STAT;
  wire hit_tmr = paddr == OFS_TMR;
  wire hit_cpr = paddr == OFS_CPR;
  wire hit_cpw = paddr == OFS_CPW;
  wire hit_prd = paddr == OFS_PRD;
  wire hit_is  = paddr == OFS_ISTS;
  wire hit_ic  = paddr == OFS_ICLR;
  wire hit_ie  = paddr == OFS_IEN;
  wire mapped  = hit_ctl | hit_sts | hit_tmr | hit_cpr | hit_cpw
               | hit_prd | hit_is | hit_ic | hit_ie;
  wire wr_ctl  = wr & hit_ctl;
  wire wr_sts  = wr & hit_sts;
  wire wr_prd  = wr & hit_prd;
  wire wr_ic   = wr & hit_ic;
  wire wr_ie   = wr & hit_ie;

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  //////////////////////////////////////////////////////////////////
  smtc_edge #(
    .N (2)
  ) u_edge (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .lvl     ({measured_signal, window_input}),
    .rise    ({sig_rise, win_rise}),
    .fall    ({sig_fall, win_fall})
  );

  //////////////////////////////////////////////////////////////////
  // mode decode; unlisted codes (incl. 1111) do nothing
  always_comb
  begin
    mode_ok   = 1'b1;
    need_edge = 1'b0;
    inc       = 1'b0;
    restart   = 1'b0;
    ld_per    = 1'b0;
    ld_wid    = 1'b0;
    case (mode)
      MD_WINCNT:
      begin
        need_edge = 1'b1;
        inc       = sig_rise;
        restart   = win_rise;
        ld_per    = win_rise;
        ld_wid    = win_fall;
      end
      MD_GATED:
        inc = window_input;
      MD_COUNT:
        inc = 1'b1;
      MD_CAPT:
      begin
        inc    = 1'b1;
        ld_per = sig_rise;
        ld_wid = sig_fall;
      end
      MD_TOF:
      begin
        need_edge = 1'b1;
        inc       = 1'b1;
        restart   = win_rise;
        ld_per    = sig_rise;
      end
      MD_GWIN:
      begin
        need_edge = 1'b1;
        inc       = measured_signal & window_input;
        restart   = win_rise;
        ld_per    = win_rise;
      end
      MD_WIN:
      begin
        need_edge = 1'b1;
        inc       = 1'b1;
        restart   = win_rise;
        ld_per    = win_rise;
      end
      MD_HILO:
      begin
        inc     = 1'b1;
        restart = sig_rise | sig_fall;
        ld_per  = sig_rise; // low time
        ld_wid  = sig_fall; // high time
      end
      default:
        mode_ok = 1'b0;
    endcase
  end

  wire acq      = st == ST_ACQ;
  wire start_ev = need_edge ? win_rise : 1'b1;
  wire cnt_en   = acq & inc;
  wire match    = cnt_en & (main_counter == period_limit);
  wire acq_done = acq & ld_per;
  wire wid_done = acq & ld_wid;
  //////////////////////////////////////////////////////////////////
  // acquisition state
  always_comb
  begin
    next_st = st;
    case (st)
      ST_IDLE:
        if (acquisition_go)
          next_st = ST_ARM;
      ST_ARM:
        if (!acquisition_go)
          next_st = ST_IDLE;
        else if (mode_ok && start_ev)
          next_st = ST_ACQ;
      ST_ACQ:
        if (!acquisition_go || !mode_ok)
          next_st = ST_IDLE;
      default:
        next_st = ST_IDLE;
    endcase
  end

  // software write of go wins over the hardware clear
  always_comb
  begin
    next_go = acquisition_go;
    if (wr_ctl)
      next_go = pwdata[B_GO];
    else if (acq_done && !rep)
      next_go = 1'b0;
  end

  always_comb
  begin
    next_count = main_counter;
    if (counter_clear_req)
      next_count = '0;
    else if (st == ST_ARM && mode_ok && start_ev)
      next_count = '0;
    else if (acq && restart)
      next_count = '0;
    else if (match)
      next_count = '0;
    else if (cnt_en)
      next_count = main_counter + 24'h1;
  end

  //////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st             <= ST_IDLE;
      acquisition_go <= 1'b0;
      main_counter   <= '0;
    end
    else
    begin
      st             <= next_st;
      acquisition_go <= next_go;
      main_counter   <= next_count;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rep          <= 1'b0;
      mode         <= '0;
      period_limit <= PRD_RST;
      ien          <= '0;
    end
    else
    begin
      if (wr_ctl)
      begin
        rep  <= pwdata[B_REP];
        mode <= pwdata[MODE_HI:0];
      end
      if (wr_prd)
        period_limit <= pwdata[CW-1:0];
      if (wr_ie)
        ien <= pwdata[IRQ_N-1:0];
    end
  end

  // requests live one cycle: copy/reset happens, then bit clears
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      period_buffer_update_req <= 1'b0;
      width_buffer_update_req  <= 1'b0;
      counter_clear_req        <= 1'b0;
    end
    else
    begin
      period_buffer_update_req <= wr_sts & pwdata[B_PUPD];
      width_buffer_update_req  <= wr_sts & pwdata[B_WUPD];
      counter_clear_req        <= wr_sts & pwdata[B_MCLR];
    end
  end

  //////////////////////////////////////////////////////////////////
  smtc_capt u_cpr (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .load    (acq_done | period_buffer_update_req),
    .d       (main_counter),
    .q       (period_capture)
  );
  smtc_capt u_cpw (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .load    (wid_done | width_buffer_update_req),
    .d       (main_counter),
    .q       (width_capture)
  );

  //////////////////////////////////////////////////////////////////
  // sticky events, set beats write-one clear
  wire [IRQ_N-1:0] ev = {match, acq_done, wid_done};
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      ists <= '0;
    else if (wr_ic)
      ists <= (ists & ~pwdata[IRQ_N-1:0]) | ev;
    else
      ists <= ists | ev;
  end
  assign irq = |(ists & ien);
  //////////////////////////////////////////////////////////////////
  wire [7:0] ctl_rd = {acquisition_go, rep, 2'b00, mode};
  wire [7:0] sts_rd = {period_buffer_update_req,
                       width_buffer_update_req,
                       counter_clear_req, 2'b00,
                       cnt_en,
                       window_input,
                       acq};

  always_comb
  begin
    rd_mux = '0;
    case (1'b1)
      hit_ctl: rd_mux = {24'h0, ctl_rd};
      hit_sts: rd_mux = {24'h0, sts_rd};
      hit_tmr: rd_mux = {8'h0, main_counter};
      hit_cpr: rd_mux = {8'h0, period_capture};
      hit_cpw: rd_mux = {8'h0, width_capture};
      hit_prd: rd_mux = {8'h0, period_limit};
      hit_is:  rd_mux = {29'h0, ists};
      hit_ie:  rd_mux = {29'h0, ien};
      default: rd_mux = '0;
    endcase
  end

  // sampled in setup so the access phase sees stable data
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      prdata <= '0;
    else if (setup && !pwrite)
      prdata <= rd_mux;
  end
  //////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_arm_start;
    st == ST_ARM && acquisition_go && mode_ok && start_ev;
  endsequence
  sequence s_period_req;
    period_buffer_update_req && !(wr_sts && pwdata[B_PUPD]);
  endsequence
  AST_GO_STOP: assert property (!acquisition_go |=> st == ST_IDLE)
    else $error("state not idle after go cleared");
  AST_NO_COUNT: assert property ((st != ST_ACQ && !counter_clear_req
      && !(st == ST_ARM && mode_ok && start_ev))
      |=> main_counter == $past(main_counter))
    else $error("counter moved while stopped");
  AST_SINGLE: assert property ((acq_done && !rep && !wr_ctl)
      |=> !acquisition_go ##1 st == ST_IDLE)
    else $error("single acquisition did not stop");
  AST_REPEAT: assert property ((acq_done && rep && !wr_ctl) |=> acquisition_go)
    else $error("repeat acquisition stopped");
  // a mode write lands while acquiring; the state leaves one cycle later
  AST_RESERVED: assert property (mode == 4'hf |=> st != ST_ACQ)
    else $error("reserved mode acquiring");
  AST_COUNT: assert property ((mode == MD_COUNT && acq && !match
      && !counter_clear_req)
      |=> main_counter == $past(main_counter) + 24'h1)
    else $error("counter mode did not increment");
  AST_ACQ_FLAG: assert property (s_arm_start |=> acq ##0 sts_rd[B_ACQ])
    else $error("acquisition flag not set after start");
  AST_PER_UPD: assert property (s_period_req
      |=> !period_buffer_update_req
      && period_capture == $past(main_counter))
    else $error("period update request mishandled");
  AST_MCLR: assert property (counter_clear_req |=> main_counter == 24'h0)
    else $error("manual clear did not reset counter");
  AST_WIN_WID: assert property ((mode == MD_WINCNT && acq && win_fall)
      |=> width_capture == $past(main_counter))
    else $error("window fall did not load width capture");
endmodule
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import smtc_pkg::*;
  logic          ref_clk;
  logic          rst_n;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [AW-1:0] paddr;
  logic [DW-1:0] pwdata;
  logic [DW-1:0] prdata;
  logic          pready;
  logic          pslverr;
  logic          window_input;
  logic          measured_signal;
  logic          irq;
  logic          last_err;
  int            mismatches;
  int            checks;

  smtc_top smtc_top_inst (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .psel            (psel),
    .penable         (penable),
    .pwrite          (pwrite),
    .paddr           (paddr),
    .pwdata          (pwdata),
    .prdata          (prdata),
    .pready          (pready),
    .pslverr         (pslverr),
    .window_input    (window_input),
    .measured_signal (measured_signal),
    .irq             (irq)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // one apb transfer; starts at a fresh edge so no signal is driven twice per step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1)
    begin
      @(posedge ref_clk);
    end
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    apb(1'b1, a, d, dummy);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    apb(1'b0, a, 32'h0, d);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    rd(OFS_CTL1, d);
    chk(d, 32'h0, "control reset");
    rd(OFS_STAT, d);
    chk(d, 32'h0, "status reset");
    rd(OFS_PRD, d);
    chk(d, {8'h0, PRD_RST}, "limit reset");
    rd(8'h40, d);
    chk({31'h0, last_err}, 32'h1, "unmapped error");
    chk(d, 32'h0, "unmapped data");
    $display("test reset done");
  endtask

  // free counting, stop, manual copy and manual clear
  task automatic t_count();
    logic [31:0] a;
    logic [31:0] b;
    wr(OFS_CTL1, 32'h88);
    cyc(10);
    rd(OFS_STAT, a);
    chk(a & 32'h7, 32'h5, "running and acquiring");
    rd(OFS_TMR, a);
    rd(OFS_TMR, b);
    chk({31'h0, b > a}, 32'h1, "counter increments");
    wr(OFS_CTL1, 32'h08);
    cyc(3);
    rd(OFS_TMR, a);
    rd(OFS_TMR, b);
    chk(b, a, "counter halted");
    rd(OFS_STAT, b);
    chk(b & 32'h7, 32'h0, "idle flags");
    wr(OFS_STAT, 32'hc0);
    cyc(2);
    rd(OFS_CPR, b);
    chk(b, a, "manual period copy");
    rd(OFS_CPW, b);
    chk(b, a, "manual width copy");
    rd(OFS_STAT, b);
    chk(b & 32'he0, 32'h0, "update requests self clear");
    wr(OFS_STAT, 32'h20);
    cyc(2);
    rd(OFS_TMR, b);
    chk(b, 32'h0, "manual counter clear");
    rd(OFS_STAT, b);
    chk(b & 32'h20, 32'h0, "clear request self clears");
    $display("test count done");
  endtask

  task automatic t_reserved();
    logic [31:0] d;
    wr(OFS_CTL1, 32'h8f);
    cyc(6);
    rd(OFS_STAT, d);
    chk(d & 32'h5, 32'h0, "reserved mode idle");
    rd(OFS_TMR, d);
    chk(d, 32'h0, "reserved mode no count");
    wr(OFS_CTL1, 32'h0);
    $display("test reserved done");
  endtask

  // single capture ends the run and raises the period interrupt
  task automatic t_single();
    logic [31:0] d;
    wr(OFS_IEN, 32'h2);
    wr(OFS_CTL1, 32'h87);
    cyc(8);
    rd(OFS_STAT, d);
    chk(d & 32'h1, 32'h1, "acquiring");
    measured_signal <= 1'b1;
    cyc(8);
    rd(OFS_CTL1, d);
    chk(d, 32'h07, "go cleared by hardware");
    rd(OFS_STAT, d);
    chk(d & 32'h5, 32'h0, "stopped after one");
    rd(OFS_CPR, d);
    chk({31'h0, d != 0}, 32'h1, "period captured");
    chk({31'h0, irq}, 32'h1, "irq raised");
    wr(OFS_IEN, 32'h0);
    cyc(1);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(OFS_IEN, 32'h2);
    wr(OFS_ICLR, 32'h2);
    cyc(1);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rd(OFS_ISTS, d);
    chk(d & 32'h2, 32'h0, "status cleared");
    measured_signal <= 1'b0;
    wr(OFS_IEN, 32'h0);
    $display("test single done");
  endtask

  // each listed mode is counting while the window is open
  task automatic t_modes();
    logic [3:0]  m [7] = '{4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3};
    logic [31:0] d;
    for (int i = 0; i < 7; i++)
    begin
      measured_signal <= 1'b1;
      wr(OFS_CTL1, {24'h0, 4'hc, m[i]});
      cyc(4);
      rd(OFS_STAT, d);
      chk(d & 32'h2, 32'h0, "window closed");
      if (m[i] == 4'h9)
        chk(d & 32'h4, 32'h0, "gated holds");
      window_input <= 1'b1;
      cyc(6);
      rd(OFS_STAT, d);
      chk(d & 32'h6, 32'h6, "mode counts in window");
      wr(OFS_CTL1, 32'h0);
      window_input    <= 1'b0;
      measured_signal <= 1'b0;
      cyc(3);
    end
    $display("test modes done");
  endtask

  task automatic t_wincnt();
    logic [31:0] d;
    wr(OFS_CTL1, 32'hca);
    cyc(4);
    window_input <= 1'b1;
    cyc(4);
    repeat (3)
    begin
      measured_signal <= 1'b1;
      cyc(4);
      measured_signal <= 1'b0;
      cyc(4);
    end
    window_input <= 1'b0;
    cyc(4);
    rd(OFS_CPW, d);
    chk(d, 32'h3, "width holds pulse count");
    window_input <= 1'b1;
    cyc(4);
    rd(OFS_CPR, d);
    chk(d, 32'h3, "period holds pulse count");
    rd(OFS_ISTS, d);
    chk(d & 32'h3, 32'h3, "capture events");
    wr(OFS_CTL1, 32'h0);
    window_input <= 1'b0;
    $display("test windowed counter done");
  endtask

  // period match wraps the counter and raises its interrupt
  task automatic t_match();
    logic [31:0] d;
    wr(OFS_PRD, 32'h5);
    wr(OFS_ICLR, 32'h7);
    wr(OFS_IEN, 32'h4);
    wr(OFS_CTL1, 32'h88);
    cyc(12);
    rd(OFS_ISTS, d);
    chk(d & 32'h4, 32'h4, "period match event");
    chk({31'h0, irq}, 32'h1, "match irq");
    rd(OFS_TMR, d);
    chk({31'h0, d <= 32'h5}, 32'h1, "counter wraps at limit");
    wr(OFS_CTL1, 32'h0);
    wr(OFS_ICLR, 32'h7);
    rd(OFS_ISTS, d);
    chk(d, 32'h0, "events cleared");
    chk({31'h0, irq}, 32'h0, "irq idle");
    rd(OFS_ICLR, d);
    chk(d, 32'h0, "clear register reads zero");
    $display("test match done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n           = 1'b0;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 8'h00;
    pwdata          = 32'h0;
    window_input    = 1'b0;
    measured_signal = 1'b0;
    mismatches      = 0;
    checks          = 0;
    cyc(20);
    rst_n <= 1'b1;
    t_reset();
    t_count();
    t_reserved();
    t_single();
    t_modes();
    t_wincnt();
    t_match();
    test_done();
  end

  // all tests need well under 3000 cycles
  initial
  begin
    cyc(20000);
    mismatches++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end
endmodule
`default_nettype wire
